/* hdl/mac_event_pkg.sv */
// constants for the mac event status block: register map, bit positions, reset values
// assumes a 32-bit apb slave port
package mac_event_pkg;
  localparam logic [7:0]  OFS_TX_QUEUE    = 8'h00;
  localparam logic [7:0]  OFS_RX_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_EV_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_EV_ENABLE   = 8'h0c;
  localparam logic [7:0]  OFS_EV_DISABLE  = 8'h10;
  localparam logic [7:0]  OFS_EV_MASK     = 8'h14;
  localparam logic [7:0]  OFS_PAUSE_TIME  = 8'h38;

  localparam int RX_NO_BUFFER      = 0;
  localparam int RX_FRAME_STORED   = 1;
  localparam int RX_OVERRUN_STATUS = 2;
  localparam int RX_STATUS_W       = 3;

  localparam int EV_MGMT_DONE      = 0;
  localparam int EV_RX_COMPLETE    = 1;
  localparam int EV_RX_OWNED       = 2;
  localparam int EV_TX_OWNED       = 3;
  localparam int EV_TX_UNDERRUN    = 4;
  localparam int EV_RETRY_LIMIT    = 5;
  localparam int EV_TX_EXHAUSTED   = 6;
  localparam int EV_TX_COMPLETE    = 7;
  localparam int EV_RX_OVERRUN     = 10;
  localparam int EV_BUS_ERROR      = 11;
  localparam int EV_PAUSE_FRAME    = 12;
  localparam int EV_PAUSE_ZERO     = 13;
  localparam int EV_W              = 14;

  // implemented event bits; 8, 9 and all above 13 are unused
  localparam logic [13:0] EV_IMPL_MASK    = 14'h3cff;
  localparam logic [13:0] EV_MASK_RESET   = 14'h0000;
  localparam logic [31:0] TX_QUEUE_RESET  = 32'h0000_0000;
  localparam logic [31:0] TX_QUEUE_KEEP   = 32'hffff_fffc;
endpackage

/* hdl/mac_event_status_irq.sv */
// event status, event mask and transmit queue pointer logic of an ethernet mac
// assumes apb from the system clock domain; event inputs are one-cycle pulses on the same clock
`timescale 1ns/1ps
module mac_event_status_irq #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_fetch_owned,
  input  wire logic              rx_frame_start,
  input  wire logic              rx_frame_done,
  input  wire logic              rx_store_fail,
  input  wire logic              tx_fetch_owned,
  input  wire logic              tx_late_data,
  input  wire logic              tx_owned_midframe,
  input  wire logic              tx_frame_start,
  input  wire logic [31:0]       tx_desc_addr,
  input  wire logic              tx_active,
  input  wire logic              tx_exhausted,
  input  wire logic              tx_frame_done,
  input  wire logic              tx_retry_limit,
  input  wire logic              dma_bus_error,
  input  wire logic              mgmt_done,
  input  wire logic              pause_rx,
  input  wire logic              pause_zero,
  output logic                   rx_refetch_req,
  output logic                   rx_buffer_recover,
  output logic                   tx_queue_load,
  output logic [31:0]            tx_queue_start,
  output logic                   irq
);
  initial begin
    if (ADDR_W < 8) $error("ADDR_W must be at least 8");
  end

  logic [mac_event_pkg::RX_STATUS_W-1:0] rx_status_q;
  logic [mac_event_pkg::EV_W-1:0]        ev_status_q;
  logic [mac_event_pkg::EV_W-1:0]        ev_mask_q;
  logic [mac_event_pkg::EV_W-1:0]        ev_set;
  logic [31:0]                           tx_queue_q;
  logic [31:0]                           rd_data;
  logic                                  rx_wait_q;
  logic                                  rd_hit;
  logic                                  wr_hit;
  logic                                  ovr_rise;
  logic                                  tx_ptr_write;

  function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    reg_sel = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = reg_sel(a, mac_event_pkg::OFS_TX_QUEUE) || reg_sel(a, mac_event_pkg::OFS_RX_STATUS) ||
                 reg_sel(a, mac_event_pkg::OFS_EV_STATUS) || reg_sel(a, mac_event_pkg::OFS_EV_ENABLE) ||
                 reg_sel(a, mac_event_pkg::OFS_EV_DISABLE) || reg_sel(a, mac_event_pkg::OFS_EV_MASK);
  endfunction

  // one wait state: access completes on the second access cycle when pready is high
  assign rd_hit = clk_en && psel && penable && pready && !pwrite;
  assign wr_hit = clk_en && psel && penable && pready && pwrite && known_addr(paddr);
  // pointer is locked while the transmitter runs
  assign tx_ptr_write = wr_hit && reg_sel(paddr, mac_event_pkg::OFS_TX_QUEUE) && !tx_active;
  assign ovr_rise = rx_store_fail && !rx_status_q[mac_event_pkg::RX_OVERRUN_STATUS];

  always_comb begin
    ev_set = '0;
    ev_set[mac_event_pkg::EV_MGMT_DONE]    = mgmt_done;
    ev_set[mac_event_pkg::EV_RX_COMPLETE]  = rx_frame_done;
    ev_set[mac_event_pkg::EV_RX_OWNED]     = rx_fetch_owned;
    ev_set[mac_event_pkg::EV_TX_OWNED]     = tx_fetch_owned;
    ev_set[mac_event_pkg::EV_TX_UNDERRUN]  = tx_late_data || tx_owned_midframe ||
                                             (dma_bus_error && tx_active) || tx_ptr_write;
    ev_set[mac_event_pkg::EV_RETRY_LIMIT]  = tx_retry_limit;
    ev_set[mac_event_pkg::EV_TX_EXHAUSTED] = tx_exhausted;
    ev_set[mac_event_pkg::EV_TX_COMPLETE]  = tx_frame_done;
    ev_set[mac_event_pkg::EV_RX_OVERRUN]   = ovr_rise;
    ev_set[mac_event_pkg::EV_BUS_ERROR]    = dma_bus_error;
    ev_set[mac_event_pkg::EV_PAUSE_FRAME]  = pause_rx;
    ev_set[mac_event_pkg::EV_PAUSE_ZERO]   = pause_zero;
  end

  always_comb begin
    rd_data = '0;
    if (reg_sel(paddr, mac_event_pkg::OFS_TX_QUEUE)) begin
      rd_data = tx_queue_q;
    end else if (reg_sel(paddr, mac_event_pkg::OFS_RX_STATUS)) begin
      rd_data[mac_event_pkg::RX_STATUS_W-1:0] = rx_status_q;
    end else if (reg_sel(paddr, mac_event_pkg::OFS_EV_STATUS)) begin
      rd_data[mac_event_pkg::EV_W-1:0] = ev_status_q;
    end else if (reg_sel(paddr, mac_event_pkg::OFS_EV_MASK)) begin
      rd_data[mac_event_pkg::EV_W-1:0] = ev_mask_q;
    end
  end

  // apb handshake and read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known_addr(paddr);
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // receive status: set wins over a simultaneous one-write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_status_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < mac_event_pkg::RX_STATUS_W; i++) begin
        if (wr_hit && reg_sel(paddr, mac_event_pkg::OFS_RX_STATUS) && pwdata[i]) begin
          rx_status_q[i] <= 1'b0;
        end
      end
      if (rx_fetch_owned) rx_status_q[mac_event_pkg::RX_NO_BUFFER] <= 1'b1;
      if (rx_frame_done) rx_status_q[mac_event_pkg::RX_FRAME_STORED] <= 1'b1;
      if (rx_store_fail) rx_status_q[mac_event_pkg::RX_OVERRUN_STATUS] <= 1'b1;
    end
  end

  // event status clears on the read that returns it; new events in that cycle survive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ev_status_q <= '0;
    end else if (clk_en) begin
      if (rd_hit && reg_sel(paddr, mac_event_pkg::OFS_EV_STATUS)) begin
        ev_status_q <= ev_set & mac_event_pkg::EV_IMPL_MASK;
      end else begin
        ev_status_q <= (ev_status_q | ev_set) & mac_event_pkg::EV_IMPL_MASK;
      end
    end
  end

  // mask: one bit per source, 1 = enabled; zero bits of a write leave it alone
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ev_mask_q <= mac_event_pkg::EV_MASK_RESET;
    end else if (clk_en && wr_hit) begin
      if (reg_sel(paddr, mac_event_pkg::OFS_EV_ENABLE)) begin
        ev_mask_q <= ev_mask_q | (pwdata[mac_event_pkg::EV_W-1:0] & mac_event_pkg::EV_IMPL_MASK);
      end else if (reg_sel(paddr, mac_event_pkg::OFS_EV_DISABLE)) begin
        ev_mask_q <= ev_mask_q & ~pwdata[mac_event_pkg::EV_W-1:0];
      end
    end
  end

  // transmit queue pointer: loaded by software, tracks frame start descriptor
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_queue_q     <= mac_event_pkg::TX_QUEUE_RESET;
      tx_queue_start <= mac_event_pkg::TX_QUEUE_RESET;
      tx_queue_load  <= 1'b0;
    end else if (clk_en) begin
      tx_queue_load <= tx_ptr_write;
      if (tx_ptr_write) begin
        tx_queue_q     <= pwdata & mac_event_pkg::TX_QUEUE_KEEP;
        tx_queue_start <= pwdata & mac_event_pkg::TX_QUEUE_KEEP;
      end else if (tx_frame_start) begin
        tx_queue_q <= tx_desc_addr & mac_event_pkg::TX_QUEUE_KEEP;
      end
    end
  end

  // receive dma retry and buffer recovery requests
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_wait_q         <= 1'b0;
      rx_refetch_req    <= 1'b0;
      rx_buffer_recover <= 1'b0;
    end else if (clk_en) begin
      if (rx_fetch_owned) begin
        rx_wait_q <= 1'b1;
      end else if (rx_frame_start && rx_wait_q) begin
        rx_wait_q <= 1'b0;
      end
      rx_refetch_req    <= rx_frame_start && rx_wait_q;
      rx_buffer_recover <= rx_store_fail;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(ev_status_q & ev_mask_q);
    end
  end

  // checks
  sequence s_owned_fetch;
    clk_en && rx_fetch_owned;
  endsequence

  a_no_buffer_set: assert property (@(posedge clock) disable iff (!rst_n)
    s_owned_fetch |=> rx_status_q[mac_event_pkg::RX_NO_BUFFER])
    else $error("no-buffer flag not set after owned fetch");
  a_rx_no_self_set: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !rx_frame_done && !rx_status_q[mac_event_pkg::RX_FRAME_STORED]
      |=> !rx_status_q[mac_event_pkg::RX_FRAME_STORED])
    else $error("frame-stored flag set without event");
  a_frame_stored: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rx_frame_done |=> rx_status_q[mac_event_pkg::RX_FRAME_STORED] &&
      ev_status_q[mac_event_pkg::EV_RX_COMPLETE])
    else $error("frame stored not flagged");
  a_overrun_pair: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && ovr_rise |=> ev_status_q[mac_event_pkg::EV_RX_OVERRUN] && rx_buffer_recover)
    else $error("overrun event missing");
  a_refetch_next: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rx_wait_q && rx_frame_start && !rx_fetch_owned |=> rx_refetch_req && !rx_wait_q)
    else $error("refetch not requested");
  a_status_clears: assert property (@(posedge clock) disable iff (!rst_n)
    rd_hit && reg_sel(paddr, mac_event_pkg::OFS_EV_STATUS) && ev_set == '0 |=> ev_status_q == '0)
    else $error("event status not cleared on read");
  a_underrun_ptr: assert property (@(posedge clock) disable iff (!rst_n)
    tx_ptr_write |=> ev_status_q[mac_event_pkg::EV_TX_UNDERRUN] && tx_queue_load)
    else $error("pointer write did not flag underrun");
  a_irq_follow: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && |(ev_status_q & ev_mask_q) |=> irq)
    else $error("irq not raised");
  a_enable_sets: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit && reg_sel(paddr, mac_event_pkg::OFS_EV_ENABLE) |=>
      ((ev_mask_q & $past(pwdata[mac_event_pkg::EV_W-1:0]) & mac_event_pkg::EV_IMPL_MASK) ==
       ($past(pwdata[mac_event_pkg::EV_W-1:0]) & mac_event_pkg::EV_IMPL_MASK)))
    else $error("enable write lost");
  a_disable_clrs: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit && reg_sel(paddr, mac_event_pkg::OFS_EV_DISABLE) |=>
      (ev_mask_q & $past(pwdata[mac_event_pkg::EV_W-1:0])) == '0)
    else $error("disable write lost");
  a_unused_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (ev_status_q & ~mac_event_pkg::EV_IMPL_MASK) == '0 && (ev_mask_q & ~mac_event_pkg::EV_IMPL_MASK) == '0)
    else $error("unused bit set");

  // path from an enabled event to the interrupt output takes two enabled cycles
  sequence s_enabled_event;
    clk_en && |(ev_set & ev_mask_q) &&
      !(wr_hit && reg_sel(paddr, mac_event_pkg::OFS_EV_DISABLE));
  endsequence

  sequence s_still_running;
    clk_en;
  endsequence

  a_event_to_irq: assert property (@(posedge clock) disable iff (!rst_n)
    s_enabled_event ##1 s_still_running |=> irq)
    else $error("enabled event did not reach irq");

  a_irq_low: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && (ev_status_q & ev_mask_q) == '0 |=> !irq)
    else $error("irq high with nothing enabled");

  // receive status flags and buffer recovery request
  a_ovr_set: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rx_store_fail |=> rx_status_q[mac_event_pkg::RX_OVERRUN_STATUS] && rx_buffer_recover)
    else $error("overrun status or recovery missing");

  a_recover_only: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !rx_store_fail |=> !rx_buffer_recover)
    else $error("buffer recovery without storage failure");

  a_rx_clear_bit: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit && reg_sel(paddr, mac_event_pkg::OFS_RX_STATUS) && pwdata[mac_event_pkg::RX_NO_BUFFER] &&
      !rx_fetch_owned |=> !rx_status_q[mac_event_pkg::RX_NO_BUFFER])
    else $error("no-buffer flag not cleared by written one");

  a_rx_keep_bit: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rx_status_q[mac_event_pkg::RX_OVERRUN_STATUS] &&
      !(wr_hit && reg_sel(paddr, mac_event_pkg::OFS_RX_STATUS) && pwdata[mac_event_pkg::RX_OVERRUN_STATUS])
      |=> rx_status_q[mac_event_pkg::RX_OVERRUN_STATUS])
    else $error("overrun status lost without a written one");

  a_rx_no_write_set: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit && reg_sel(paddr, mac_event_pkg::OFS_RX_STATUS) && !rx_fetch_owned &&
      !rx_status_q[mac_event_pkg::RX_NO_BUFFER] |=> !rx_status_q[mac_event_pkg::RX_NO_BUFFER])
    else $error("write set a receive status flag");

  // a low enable must freeze every piece of state, events included
  a_freeze_all: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n && !clk_en |=> $stable(ev_status_q) && $stable(ev_mask_q) &&
      $stable(rx_status_q) && $stable(tx_queue_q))
    else $error("state changed while enable low");

  // transmit queue pointer
  a_ptr_locked: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit && reg_sel(paddr, mac_event_pkg::OFS_TX_QUEUE) && tx_active && !tx_frame_start
      |=> $stable(tx_queue_q))
    else $error("pointer written while transmitter active");

  a_ptr_load: assert property (@(posedge clock) disable iff (!rst_n)
    tx_ptr_write |=> tx_queue_q == ($past(pwdata) & mac_event_pkg::TX_QUEUE_KEEP) &&
      tx_queue_start == ($past(pwdata) & mac_event_pkg::TX_QUEUE_KEEP))
    else $error("pointer write not loaded");

  a_ptr_track: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && tx_frame_start && !tx_ptr_write |=>
      tx_queue_q == ($past(tx_desc_addr) & mac_event_pkg::TX_QUEUE_KEEP))
    else $error("pointer does not show frame start descriptor");

  a_ptr_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_queue_q & ~mac_event_pkg::TX_QUEUE_KEEP) == '0)
    else $error("pointer low bits not zero");

  a_load_only: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !tx_ptr_write |=> !tx_queue_load)
    else $error("queue load without accepted write");

  // event status flags
  a_events_latch: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> ((($past(ev_set) & mac_event_pkg::EV_IMPL_MASK) & ~ev_status_q) == '0))
    else $error("event not latched");

  a_events_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !(rd_hit && reg_sel(paddr, mac_event_pkg::OFS_EV_STATUS)) |=>
      (($past(ev_status_q) & ~ev_status_q) == '0))
    else $error("event flag lost without a status read");

  a_underrun_src: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && (tx_late_data || tx_owned_midframe || (dma_bus_error && tx_active))
      |=> ev_status_q[mac_event_pkg::EV_TX_UNDERRUN])
    else $error("underrun source not flagged");

  a_tx_owned: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && tx_fetch_owned |=> ev_status_q[mac_event_pkg::EV_TX_OWNED])
    else $error("tx owned fetch not flagged");

  // mask register, apb error response and refetch request
  a_mask_zero_write: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit && (reg_sel(paddr, mac_event_pkg::OFS_EV_ENABLE) || reg_sel(paddr, mac_event_pkg::OFS_EV_DISABLE)) &&
      pwdata[mac_event_pkg::EV_W-1:0] == '0 |=> $stable(ev_mask_q))
    else $error("zero write changed the mask");

  a_mask_hold: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !wr_hit |=> $stable(ev_mask_q))
    else $error("mask changed without a write");

  a_slverr_ready: assert property (@(posedge clock) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error response without ready");

  a_refetch_only: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !(rx_frame_start && rx_wait_q) |=> !rx_refetch_req)
    else $error("refetch without waiting frame start");
endmodule

/* test/mac_event_status_irq_tb.sv */
// bench for the mac event status block: apb register traffic and event pulses
// assumes the design package and one 200 mhz clock with a synchronous active-low reset
`timescale 1ns/1ps
module mac_event_status_irq_tb;
  logic        clock, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        tx_active, tx_start, rx_refetch_req, rx_buffer_recover, tx_queue_load, irq, err;
  logic [7:0]  paddr;
  logic [13:0] ev;
  logic [31:0] pwdata, prdata, tx_desc_addr, tx_queue_start, rd, r, msk;
  int          num_errors, comparisons, refetch_cnt, recover_cnt, load_cnt;

  mac_event_status_irq u_dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_fetch_owned(ev[2]), .rx_frame_start(ev[9]), .rx_frame_done(ev[1]), .rx_store_fail(ev[10]),
    .tx_fetch_owned(ev[3]), .tx_late_data(ev[4]), .tx_owned_midframe(ev[8]), .tx_frame_start(tx_start),
    .tx_desc_addr(tx_desc_addr), .tx_active(tx_active), .tx_exhausted(ev[6]), .tx_frame_done(ev[7]),
    .tx_retry_limit(ev[5]), .dma_bus_error(ev[11]), .mgmt_done(ev[0]), .pause_rx(ev[12]),
    .pause_zero(ev[13]), .rx_refetch_req(rx_refetch_req), .rx_buffer_recover(rx_buffer_recover),
    .tx_queue_load(tx_queue_load), .tx_queue_start(tx_queue_start), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // pulse outputs are counted rather than caught in one cycle, so a late pulse still shows
  always @(posedge clock) begin
    if (rx_refetch_req === 1'b1) refetch_cnt++;
    if (rx_buffer_recover === 1'b1) recover_cnt++;
    if (tx_queue_load === 1'b1) load_cnt++;
  end

  // event index to expected event status bits, with tx_active low
  function automatic logic [31:0] exp_ev(input int i);
    case (i)
      8: exp_ev = 32'h10;
      9: exp_ev = 32'h0;
      default: exp_ev = 32'h1 << i;
    endcase
  endfunction

  function automatic logic [31:0] exp_rx(input int i);
    case (i)
      1: exp_rx = 32'h2;
      2: exp_rx = 32'h1;
      10: exp_rx = 32'h4;
      default: exp_rx = 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic pulse(input int i);
    @(posedge clock);
    ev <= 14'h1 << i;
    @(posedge clock);
    ev <= 14'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(1359));
    {rst_n, psel, penable, pwrite, tx_active, tx_start, err} = '0;
    {num_errors, comparisons, refetch_cnt, recover_cnt, load_cnt} = '0;
    clk_en = 1'b1;
    paddr = 8'h0;
    ev = 14'h0;
    pwdata = 32'h0;
    tx_desc_addr = 32'h0;
    msk = 32'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rdchk(8'(a * 4), 32'h0);
    end
    apb(1'b1, 8'h18, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h18, 32'h0);
    repeat (8) begin
      r = $urandom;
      apb(1'b1, mac_event_pkg::OFS_EV_ENABLE, r);
      msk = (msk | r) & {18'h0, mac_event_pkg::EV_IMPL_MASK};
      rdchk(mac_event_pkg::OFS_EV_MASK, msk);
      r = $urandom & $urandom;
      apb(1'b1, mac_event_pkg::OFS_EV_DISABLE, r);
      msk = msk & ~r;
      rdchk(mac_event_pkg::OFS_EV_MASK, msk);
    end
    apb(1'b1, mac_event_pkg::OFS_EV_ENABLE, 32'h0);
    apb(1'b1, mac_event_pkg::OFS_EV_DISABLE, 32'h0);
    rdchk(mac_event_pkg::OFS_EV_MASK, msk);
    rdchk(mac_event_pkg::OFS_EV_ENABLE, 32'h0);
    apb(1'b1, mac_event_pkg::OFS_EV_DISABLE, 32'hffff_ffff);
    for (int i = 0; i < 14; i++) begin
      pulse(i);
      rdchk(mac_event_pkg::OFS_EV_STATUS, exp_ev(i));
      rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h0);
      apb(1'b1, mac_event_pkg::OFS_RX_STATUS, 32'hffff_fff8);
      rdchk(mac_event_pkg::OFS_RX_STATUS, exp_rx(i));
      apb(1'b1, mac_event_pkg::OFS_RX_STATUS, 32'h7);
      rdchk(mac_event_pkg::OFS_RX_STATUS, 32'h0);
    end
    chk(32'(recover_cnt), 32'h1);
    pulse(2);
    pulse(9);
    chk(32'(refetch_cnt), 32'h2);
    pulse(2);
    rdchk(mac_event_pkg::OFS_RX_STATUS, 32'h1);
    rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h4);
    r = $urandom;
    apb(1'b1, mac_event_pkg::OFS_TX_QUEUE, r);
    @(posedge clock);
    rdchk(mac_event_pkg::OFS_TX_QUEUE, r & mac_event_pkg::TX_QUEUE_KEEP);
    chk(32'(load_cnt), 32'h1);
    chk(tx_queue_start, r & mac_event_pkg::TX_QUEUE_KEEP);
    rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h10);
    tx_active <= 1'b1;
    apb(1'b1, mac_event_pkg::OFS_TX_QUEUE, ~r);
    rdchk(mac_event_pkg::OFS_TX_QUEUE, r & mac_event_pkg::TX_QUEUE_KEEP);
    pulse(11);
    rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h810);
    @(posedge clock);
    tx_desc_addr <= $urandom;
    tx_start <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    rdchk(mac_event_pkg::OFS_TX_QUEUE, tx_desc_addr & mac_event_pkg::TX_QUEUE_KEEP);
    tx_active <= 1'b0;
    clk_en <= 1'b0;
    pulse(12);
    clk_en <= 1'b1;
    rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h0);
    apb(1'b1, mac_event_pkg::OFS_EV_ENABLE, 32'h80);
    pulse(0);
    chk({31'h0, irq}, 32'h0);
    pulse(7);
    chk({31'h0, irq}, 32'h1);
    rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h81);
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h0);
    pulse(7);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rdchk(mac_event_pkg::OFS_EV_STATUS, 32'h0);
    rdchk(mac_event_pkg::OFS_EV_MASK, 32'h0);
    complete_run();
  end
endmodule
